// ---- inc/sar_ctrl_defines.svh ----
`ifndef SAR_CTRL_DEFINES_SVH
`define SAR_CTRL_DEFINES_SVH

// ----------------------------------------
// resolution and rates
// ----------------------------------------
`define SAR_RES_BITS 12
`define SAR_MAX_RATE_SPS 1_000_000
`define SAR_CLK_HZ 250_000_000
`define SAR_CLK_PERIOD_PS 4_000
`define SAR_CONV_CLK_MAX_HZ 16_000_000
// conversion clock is a divided tick; round the divider up so it never exceeds the limit
`define SAR_CONV_DIV ((`SAR_CLK_HZ + `SAR_CONV_CLK_MAX_HZ - 1) / `SAR_CONV_CLK_MAX_HZ)
`define SAR_TICKS_PER_SAMPLE 16
`define SAR_SAMPLE_TICKS (`SAR_TICKS_PER_SAMPLE - `SAR_RES_BITS - 1)

// ----------------------------------------
// settling wait after power-up or wake
// ----------------------------------------
`define SAR_SETTLE_NS 10_000
`define SAR_SETTLE_CYC ((`SAR_SETTLE_NS * 1000 + `SAR_CLK_PERIOD_PS - 1) / `SAR_CLK_PERIOD_PS)

// ----------------------------------------
// storage and reset values
// ----------------------------------------
`define SAR_BUF_DEPTH 2
`define SAR_CODE_RESET 12'h000
`define SAR_CODE_MSB 12'h800

`endif

// ---- inc/sar_types_pkg.sv ----
`include "sar_ctrl_defines.svh"

package sar_types_pkg;

    typedef enum logic [4:0] {
        ST_SETTLE = 5'b0_0001,
        ST_IDLE = 5'b0_0010,
        ST_SAMPLE = 5'b0_0100,
        ST_BITS = 5'b0_1000,
        ST_STORE = 5'b1_0000
    } ctrl_state_t;

    typedef struct packed {
        logic cont;
        logic [`SAR_RES_BITS-1:0] code;
    } result_t;

endpackage

// ---- testbench/sar_adc_conversion_control_tb_top.sv ----
`timescale 1ns/1ps

module sar_adc_conversion_control_tb_top
    import sar_types_pkg::*;
;
    logic clock, rst_b, ce, start, single_conv, wake, frame_start, stall;
    logic sample_hold, busy, done_status, result_valid, result_ready;
    logic [11:0] vin, dac_code;
    result_t result_word, last_word;
    int got, bad_count, checked, n;
    logic comp_in;
    logic [11:0] codes [5] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'hA5C};

    // ideal comparator against a held input level
    assign comp_in = (vin >= dac_code);

    // short settle keeps the run brief; the divider stays at its default of 16, giving 15.625 MHz
    sar_adc_conversion_control #(.SETTLE_CYC(20)) dut (
        .clock(clock), .rst_b(rst_b), .ce(ce), .start(start), .single_conv(single_conv),
        .wake(wake), .frame_start(frame_start), .comp_in(comp_in),
        .sample_hold(sample_hold), .dac_code(dac_code), .busy(busy),
        .done_status(done_status), .result_valid(result_valid),
        .result_ready(result_ready), .result_word(result_word)
    );

    sar_result_reader reader (
        .clock(clock), .ce(ce), .stall(stall), .result_valid(result_valid),
        .result_ready(result_ready), .result_word(result_word),
        .last_word(last_word), .got(got)
    );

    initial clock = 1'b0;
    always #2 clock = ~clock;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task final_report;
        if (bad_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task chk_bit(input logic g, input logic e, input string what);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task chk_word(input result_t g, input result_t e, input string what);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h", $time, what, g);
        end
    endtask

    task tick(input int k);
        repeat (k) @(posedge clock);
    endtask

    task pulse_start;
        @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
    endtask

    // held several cycles since the pin is synchronised
    task pulse_frame;
        @(posedge clock);
        frame_start <= 1'b1;
        tick(4);
        frame_start <= 1'b0;
    endtask

    task wait_got(input int target);
        int k;
        k = 0;
        while (got < target && k < 1500) begin
            @(posedge clock);
            k++;
        end
        #1;
        chk_bit(got >= target, 1'b1, "result never delivered");
    endtask

    task quiet(input int k, input string what);
        logic seen;
        seen = 1'b0;
        repeat (k) begin
            @(posedge clock);
            #1;
            if (busy !== 1'b0) seen = 1'b1;
        end
        chk_bit(seen, 1'b0, what);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_settle;
        pulse_start;
        quiet(30, "start taken during settle");
    endtask

    task t_single;
        for (int i = 0; i < 5; i++) begin
            vin = codes[i];
            n = got;
            pulse_start;
            wait_got(n + 1);
            chk_word(last_word, result_t'{1'b0, codes[i]}, "single result");
        end
    endtask

    task t_done_hold;
        vin = 12'h3C6;
        n = got;
        @(posedge clock);
        stall <= 1'b1;
        pulse_start;
        for (int k = 0; k < 400 && result_valid !== 1'b1; k++) @(posedge clock);
        tick(10);
        stall <= 1'b0;
        #1;
        chk_bit(result_valid, 1'b1, "done dropped before read");
        chk_bit(done_status, 1'b1, "status not set");
        wait_got(n + 1);
        tick(2);
        #1;
        chk_bit(result_valid, 1'b0, "done kept after read");
        chk_bit(done_status, 1'b0, "status kept after read");
        chk_word(last_word, result_t'{1'b0, 12'h3C6}, "held result");
    endtask

    task t_busy_ignore;
        vin = 12'h155;
        n = got;
        pulse_start;
        tick(20);
        #1;
        chk_bit(busy, 1'b1, "no conversion started");
        pulse_start;
        pulse_frame;
        wait_got(n + 1);
        chk_word(last_word, result_t'{1'b0, 12'h155}, "disturbed result");
        quiet(150, "trigger during busy kept");
        chk_bit(got == n + 1, 1'b1, "extra result");
    endtask

    task t_frame;
        for (int i = 0; i < 2; i++) begin
            vin = codes[i + 3];
            n = got;
            pulse_frame;
            wait_got(n + 1);
            chk_word(last_word, result_t'{1'b0, codes[i + 3]}, "frame result");
            quiet(150, "more than one per trigger");
        end
    endtask

    task t_cont;
        vin = 12'h9E1;
        n = got;
        @(posedge clock);
        stall <= 1'b1;
        single_conv <= 1'b0;
        pulse_start;
        tick(400);
        stall <= 1'b0;
        #1;
        chk_bit(result_valid, 1'b1, "stalled buffer lost data");
        wait_got(n + 5);
        chk_word(last_word, result_t'{1'b1, 12'h9E1}, "continuous result");
        @(posedge clock);
        single_conv <= 1'b1;
        // the conversion already running still finishes and is delivered
        tick(320);
        n = got;
        quiet(200, "continuous did not stop");
        chk_bit(got == n, 1'b1, "result after stop");
    endtask

    task t_wake;
        vin = 12'h0F0;
        pulse_start;
        tick(20);
        wake <= 1'b1;
        @(posedge clock);
        wake <= 1'b0;
        tick(3);
        #1;
        chk_bit(busy, 1'b0, "wake did not abort");
        n = got;
        pulse_start;
        quiet(40, "start taken after wake");
        chk_bit(got == n, 1'b1, "aborted result delivered");
        pulse_start;
        wait_got(n + 1);
        chk_word(last_word, result_t'{1'b0, 12'h0F0}, "result after wake");
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        bad_count = 0;
        checked = 0;
        rst_b = 1'b0;
        ce = 1'b1;
        start = 1'b0;
        single_conv = 1'b1;
        wake = 1'b0;
        frame_start = 1'b0;
        stall = 1'b0;
        vin = 12'h000;
        tick(4);
        rst_b <= 1'b1;
        t_settle;
        t_single;
        t_done_hold;
        t_busy_ignore;
        t_frame;
        t_cont;
        t_wake;
        final_report;
    end

    // whole run is a few thousand cycles; this is several times that
    initial begin
        #100_000;
        bad_count++;
        $display("wrong value at %0t: run hung", $time);
        final_report;
    end
endmodule

// ---- testbench/sar_result_reader.sv ----
`timescale 1ns/1ps

module sar_result_reader
    import sar_types_pkg::*;
(
    input wire logic clock,
    input wire logic ce,
    input wire logic stall,
    input wire logic result_valid,
    output logic result_ready,
    input wire result_t result_word,
    output result_t last_word,
    output int got
);
    // ----------------------------------------
    // consumer standing in for cpu or dma
    // ----------------------------------------
    initial begin
        result_ready = 1'b0;
        last_word = '0;
        got = 0;
    end

    // ready moves only just after an edge; stall lets the bench back-pressure the buffer
    always @(posedge clock) begin
        if (ce && result_valid && result_ready) begin
            last_word <= result_word;
            got <= got + 1;
        end
        result_ready <= !stall;
    end
endmodule

// ---- verilog/sar_adc_conversion_control.sv ----
// Behaviour
// [RULE1] binary search, bits fixed MSB down to LSB
// [RULE2] twelve-bit results, up to one Msps
// [RULE3] conversion clock sixteen per sample, max 16 MHz
// [RULE4] start bit or frame-start begins conversion
// [RULE5] frame-start optional; continuous runs without it
// [RULE6] ten microsecond settling before first conversion
// [RULE7] completion sets status and done output
// [RULE8] done stays high until result read; done_status clears on any read without a push in the same cycle, even while a second result is still buffered
// [RULE9] done output usable for interrupt or DMA
// [RULE10] single bit: continuous or one per trigger
// [RULE11] continuous results drain by DMA via done
// [RULE12] frame-start may come from clock or logic
// [RULE13] start during busy conversion is ignored
`timescale 1ns/1ps

module sar_adc_conversion_control
    import sar_types_pkg::*;
#(
    parameter int RES_BITS = `SAR_RES_BITS,
    parameter int unsigned SETTLE_CYC = `SAR_SETTLE_CYC,
    parameter int unsigned CONV_DIV = `SAR_CONV_DIV,
    parameter int unsigned SAMPLE_TICKS = `SAR_SAMPLE_TICKS,
    parameter int BUF_DEPTH = `SAR_BUF_DEPTH
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic start,
    input wire logic single_conv,
    input wire logic wake,
    input wire logic frame_start,
    input wire logic comp_in,
    output logic sample_hold,
    output logic [RES_BITS-1:0] dac_code,
    output logic busy,
    output logic done_status,
    output logic result_valid,
    input wire logic result_ready,
    output result_t result_word
);

    // ----------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------
    logic [1:0] rst_pipe_r;
    logic rst_sync_b;
    logic [1:0] pins_s;
    logic fs_s;
    logic comp_s;
    logic fs_prev_r;
    logic fs_rise;
    logic trig;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe_r <= 2'b00;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_pipe_r[1];

    sar_pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .clock(clock),
        .rst_b(rst_sync_b),
        .ce(ce),
        .async_in({frame_start, comp_in}),
        .sync_out(pins_s)
    );
    assign fs_s = pins_s[1];
    assign comp_s = pins_s[0];

    // an unconnected frame-start pin simply never produces an edge
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            fs_prev_r <= 1'b0;
        end else if (ce) begin
            fs_prev_r <= fs_s;
        end
    end
    assign fs_rise = fs_s && !fs_prev_r; // [RULE12]
    assign trig = ce && (start || fs_rise); // [RULE4] [RULE5]

    // ----------------------------------------
    // conversion clock tick
    // ----------------------------------------
    localparam int DW = 8;
    logic [DW-1:0] div_cnt_r;
    logic tick;

    // one tick per conversion clock, never above the 16 MHz limit
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            div_cnt_r <= '0;
        end else if (ce) begin
            div_cnt_r <= (div_cnt_r == DW'(CONV_DIV - 1)) ? '0 : DW'(div_cnt_r + 1'b1); // [RULE3]
        end
    end
    assign tick = ce && (div_cnt_r == DW'(CONV_DIV - 1));

    // ----------------------------------------
    // control state
    // ----------------------------------------
    localparam int IW = $clog2(RES_BITS);
    ctrl_state_t state_r;
    logic [15:0] settle_cnt_r;
    logic settle_done;
    logic [3:0] phase_r;
    logic phase_last;
    logic [IW-1:0] bit_idx_r;
    logic [RES_BITS-1:0] code_r;
    logic pend_r;
    logic run_r;
    logic leave_idle;
    logic buf_in_valid;
    logic buf_in_ready;
    logic push;
    logic read;
    result_t buf_in;

    assign settle_done = (settle_cnt_r == 16'(SETTLE_CYC - 1));
    assign phase_last = (phase_r == 4'(SAMPLE_TICKS - 1));
    assign leave_idle = tick && (pend_r || run_r);
    assign buf_in_valid = (state_r == ST_STORE) && tick;
    assign push = buf_in_valid && buf_in_ready;

    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_r <= ST_SETTLE;
        end else if (ce) begin
            if (wake) begin
                state_r <= ST_SETTLE; // [RULE6]
            end else begin
                unique case (state_r)
                    ST_SETTLE: begin
                        if (settle_done) begin
                            state_r <= ST_IDLE; // [RULE6]
                        end
                    end
                    ST_IDLE: begin
                        if (leave_idle) begin
                            state_r <= ST_SAMPLE;
                        end
                    end
                    ST_SAMPLE: begin
                        if (tick && phase_last) begin
                            state_r <= ST_BITS;
                        end
                    end
                    ST_BITS: begin
                        if (tick && bit_idx_r == '0) begin
                            state_r <= ST_STORE;
                        end
                    end
                    ST_STORE: begin
                        // a full buffer holds the converter here
                        if (push) begin
                            state_r <= (run_r && !single_conv) ? ST_SAMPLE : ST_IDLE; // [RULE10] [RULE11]
                        end
                    end
                    default: begin
                        state_r <= ST_SETTLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            settle_cnt_r <= '0;
        end else if (ce) begin
            if (wake || state_r != ST_SETTLE) begin
                settle_cnt_r <= '0;
            end else if (!settle_done) begin
                settle_cnt_r <= 16'(settle_cnt_r + 1'b1); // [RULE6]
            end
        end
    end

    // triggers only count while idle; during settling or a conversion they drop
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pend_r <= 1'b0;
        end else if (ce) begin
            pend_r <= (state_r == ST_IDLE) && !wake && !leave_idle && (pend_r || trig); // [RULE13]
        end
    end

    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            run_r <= 1'b0;
        end else if (ce) begin
            if (wake || single_conv) begin
                run_r <= 1'b0; // [RULE10]
            end else if (state_r == ST_IDLE && trig) begin
                run_r <= 1'b1; // [RULE11]
            end
        end
    end

    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            phase_r <= '0;
        end else if (ce) begin
            if (state_r != ST_SAMPLE) begin
                phase_r <= '0;
            end else if (tick) begin
                phase_r <= 4'(phase_r + 1'b1);
            end
        end
    end

    // ----------------------------------------
    // successive approximation register
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            code_r <= `SAR_CODE_RESET;
            bit_idx_r <= '0;
        end else if (ce) begin
            if (state_r == ST_SAMPLE && tick && phase_last) begin
                code_r <= `SAR_CODE_MSB; // [RULE1]
                bit_idx_r <= IW'(RES_BITS - 1);
            end else if (state_r == ST_BITS && tick) begin
                // keep the trial bit if the input is at or above the dac
                code_r[bit_idx_r] <= comp_s; // [RULE1]
                if (bit_idx_r != '0) begin
                    code_r[bit_idx_r - 1'b1] <= 1'b1; // [RULE1]
                    bit_idx_r <= IW'(bit_idx_r - 1'b1);
                end
            end
        end
    end

    assign dac_code = code_r;
    assign sample_hold = (state_r == ST_SAMPLE);
    assign busy = (state_r == ST_SAMPLE) || (state_r == ST_BITS) || (state_r == ST_STORE);

    // ----------------------------------------
    // result buffer and done status
    // ----------------------------------------
    assign buf_in.cont = run_r;
    assign buf_in.code = code_r; // [RULE2]

    sar_result_buffer #(
        .WIDTH($bits(result_t)),
        .DEPTH(BUF_DEPTH)
    ) u_result_buffer (
        .clock(clock),
        .rst_b(rst_sync_b),
        .ce(ce),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(buf_in),
        .out_valid(result_valid), // [RULE7] [RULE8] [RULE9]
        .out_ready(result_ready),
        .out_data(result_word)
    );
    assign read = ce && result_valid && result_ready;

    // set wins over a read in the same cycle
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            done_status <= 1'b0;
        end else if (push) begin
            done_status <= 1'b1; // [RULE7]
        end else if (read) begin
            done_status <= 1'b0; // [RULE8]
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [4:0] tick_cnt_r;

    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tick_cnt_r <= '0;
        end else if (state_r != ST_SAMPLE && state_r != ST_BITS) begin
            tick_cnt_r <= '0;
        end else if (tick) begin
            tick_cnt_r <= 5'(tick_cnt_r + 1'b1);
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_sync_b);

    sequence s_enter_bits;
        state_r == ST_SAMPLE && tick && phase_last && !wake;
    endsequence

    sequence s_bit_step;
        state_r == ST_BITS && tick && bit_idx_r != '0 && !wake;
    endsequence

    sequence s_idle_trig;
        state_r == ST_IDLE && trig && !single_conv;
    endsequence

    a_msb_first: assert property ( // [RULE1]
        s_enter_bits |=> state_r == ST_BITS && dac_code == `SAR_CODE_MSB
    ) else $error("conversion did not start at the msb");

    a_bit_walk: assert property ( // [RULE1]
        s_bit_step |=> dac_code[bit_idx_r] && dac_code[bit_idx_r + 1] == $past(comp_s)
    ) else $error("bit search step wrong");

    a_conv_ticks: assert property ( // [RULE2]
        $rose(state_r == ST_STORE) |-> tick_cnt_r == 5'(SAMPLE_TICKS + RES_BITS)
    ) else $error("conversion tick count wrong");

    a_tick_period: assert property ( // [RULE3]
        tick |=> (!tick) [*8] ##1 (!tick) [*7]
    ) else $error("conversion clock too fast");

    a_trig_start: assert property ( // [RULE4]
        @(posedge clock) disable iff (!rst_sync_b || !ce || wake || single_conv)
        s_idle_trig |-> ##[1:17] state_r == ST_SAMPLE
    ) else $error("trigger did not start a conversion");

    a_settle_wait: assert property ( // [RULE6]
        $rose(state_r == ST_IDLE) && $past(state_r == ST_SETTLE)
            |-> $past(settle_cnt_r) == 16'(SETTLE_CYC - 1)
    ) else $error("settling wait cut short");

    a_done_set: assert property ( // [RULE7]
        push |=> result_valid && done_status
    ) else $error("completion not flagged");

    a_done_hold: assert property ( // [RULE8]
        result_valid && !(ce && result_ready) |=> result_valid && done_status
    ) else $error("done dropped before read");

    a_done_clear: assert property ( // [RULE8]
        read && !push |=> !done_status
    ) else $error("status not cleared by read");

    a_single_stop: assert property ( // [RULE10]
        push && single_conv && !wake |=> state_r == ST_IDLE && !run_r
    ) else $error("single mode ran on");

    a_cont_next: assert property ( // [RULE11]
        push && run_r && !single_conv && !wake |=> state_r == ST_SAMPLE
    ) else $error("continuous mode stalled");

    a_busy_ignore: assert property ( // [RULE13]
        state_r == ST_BITS && trig && !wake |=> !pend_r && (state_r inside {ST_BITS, ST_STORE})
    ) else $error("trigger disturbed running conversion");

endmodule

// ---- verilog/sar_pin_sync.sv ----
`timescale 1ns/1ps

module sar_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // first stage is read only by the second
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

// ---- verilog/sar_result_buffer.sv ----
`timescale 1ns/1ps

module sar_result_buffer #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 2
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic wr_fire;
    logic rd_fire;

    assign in_ready = (count_r != CW'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign wr_fire = ce && in_valid && in_ready;
    assign rd_fire = ce && out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (wr_fire) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (wr_fire) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_r + 1'b1);
            end
            if (rd_fire) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_r + 1'b1);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= '0;
        end else if (wr_fire && !rd_fire) begin
            count_r <= CW'(count_r + 1'b1);
        end else if (rd_fire && !wr_fire) begin
            count_r <= CW'(count_r - 1'b1);
        end
    end

endmodule
